/* src/irq_clear_level_cfg.svh */
// Offsets, field positions and reset values of the clear and level map.
// Assumes a 32-bit APB with full byte addresses on paddr.
`ifndef IRQ_CLEAR_LEVEL_CFG_SVH
`define IRQ_CLEAR_LEVEL_CFG_SVH
`define EDGE_CLEAR_OFS     32'hFFF4_0074
`define LEVEL_ONE_OFS      32'hFFF4_0078
`define LEVEL_TWO_OFS      32'hFFF4_007C
`define LEVEL_RESET        32'h0000_0000
`define LEVEL_ONE_MASK     32'h3F3F_3F3F
`define LEVEL_TWO_MASK     32'h3F3F_0000
`define CLEAR_LOW_BIT      8
`define SRC_COUNT          24
`define UNUSED_SRC_MASK    24'h48_0000
`define PEND_RESET         24'h00_0000
// Pending index of each source carrying a level field here.
`define IDX_TIMER_A        16
`define IDX_TIMER_B        17
`define IDX_IRQ1_EDGE      18
`define IDX_WRITE_POST     20
`define IDX_SYSTEM_FAIL    21
`define IDX_POWER_FAIL     23
`define IDX_DMA            14
`define IDX_INTR_ACK       15
`define IDX_MAILBOX2       12
`define IDX_MAILBOX3       13
`endif

/* src/irq_clear_level_pkg.sv */
// Types shared by the interrupt clear and level map.
// Field layout follows the level words: bits 31..24 first.
package irq_clear_level_pkg;
  typedef logic [2:0] prio_t;
  typedef struct packed {
    logic [1:0] pad3;
    prio_t      power_fail_priority;
    prio_t      abort_priority_unused;
    logic [1:0] pad2;
    prio_t      system_fail_priority;
    prio_t      posted_write_error_priority;
    logic [1:0] pad1;
    prio_t      external_priority_unused;
    prio_t      bus_irq1_edge_priority;
    logic [1:0] pad0;
    prio_t      timer_b_priority;
    prio_t      timer_a_priority;
  } level_one_t;
  typedef struct packed {
    logic [1:0]  pad3;
    prio_t       intr_ack_priority;
    prio_t       dma_priority;
    logic [1:0]  pad2;
    prio_t       mailbox_signal3_priority;
    prio_t       mailbox_signal2_priority;
    logic [15:0] pad_low;
  } level_two_t;
endpackage

/* src/local_irq_clear_and_level_map.sv */
// Edge-interrupt pending flops with write-one-to-clear and level fields.
// Assumes an APB master; source events are one-cycle synchronous pulses.
`timescale 1ns/100ps
`include "irq_clear_level_cfg.svh"
// Behaviour
// - Writing one to a clear bit resets that source's pending flop.
// - Clear bits 23..16: ack, DMA, mailbox 3..0, monitor 1, monitor 0.
// - Clear bits 15..8 clear software interrupts 7..0.
// - Each software interrupt has its own clear bit.
// - Each level byte except level two bits 15..0 holds two three-bit fields in six bits.
// - Level one top byte holds the power fail level.
// - Abort level only stores writes and routes nothing.
// - Level one bits 23..16 hold the write post error level.
// - The same byte holds the system fail level.
// - Level one bits 15..8 hold the bus IRQ1 edge level.
// - External level only stores writes and drives nothing.
// - Level one low byte holds timer A level.
// - Level one low byte holds timer B level too.
// - Level two bits 31..24 hold the DMA level.
// - The same byte holds the interrupter acknowledge level.
// - Level two bits 23..16 hold mailbox signal 2 level.
// - The same byte holds mailbox signal 3 level.
// - Clearing and setting pending flops ignores enable bits.
// - Clear bits 31..24: power fail, abort, sysfail, write post, ...
module local_irq_clear_and_level_map
  import irq_clear_level_pkg::*;
(
  input  wire logic        clock,          // System clock, 50 MHz.
  input  wire logic        reset,          // Synchronous, active high.
  input  wire logic        psel,           // APB select.
  input  wire logic        penable,        // APB access phase.
  input  wire logic        pwrite,         // APB write.
  input  wire logic [31:0] paddr,          // APB byte address.
  input  wire logic [31:0] pwdata,         // APB write data.
  input  wire logic [3:0]  pstrb,          // APB byte strobes.
  output logic      [31:0] prdata,         // APB read data.
  output logic             pready,         // APB ready.
  output logic             pslverr,        // APB error, unmapped.
  input  wire logic [23:0] source_event,   // Edge pulses, clear bit - 8.
  output logic      [23:0] pending,        // Pending flops.
  output logic      [23:0] level_request,  // Pending, masked where a level field is zero.
  output level_one_t       level_one,      // Level word one.
  output level_two_t       level_two       // Level word two.
);

  logic [31:0] level_one_reg;
  logic [31:0] level_two_reg;
  logic [31:0] next_level_one;
  logic [31:0] next_level_two;
  logic [23:0] next_pending;
  logic [31:0] next_prdata;
  logic [31:0] byte_mask;
  logic [23:0] clear_bits;
  logic        hit_clear;
  logic        hit_one;
  logic        hit_two;
  logic        wr_access;
  logic        mapped;

  assign hit_clear = (paddr == `EDGE_CLEAR_OFS);
  assign hit_one   = (paddr == `LEVEL_ONE_OFS);
  assign hit_two   = (paddr == `LEVEL_TWO_OFS);
  assign mapped    = hit_clear | hit_one | hit_two;
  assign wr_access = psel & penable & pwrite;
  // Zero wait states keep the map simple; nothing here needs to stall.
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~mapped;

  assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                      {8{pstrb[1]}}, {8{pstrb[0]}}};

  // Only bits on a strobed lane clear anything.
  assign clear_bits = (wr_access && hit_clear) ?
                      pwdata[31:8] & byte_mask[31:8] : 24'h00_0000;

  always_comb begin
    next_level_one = level_one_reg;
    next_level_two = level_two_reg;
    if (wr_access && hit_one) begin
      // Two fields per byte, bits 7..6 of each byte never store.
      next_level_one = (level_one_reg & ~byte_mask) |
                       (pwdata & byte_mask & `LEVEL_ONE_MASK);
    end
    if (wr_access && hit_two) begin
      next_level_two = (level_two_reg & ~byte_mask) |
                       (pwdata & byte_mask & `LEVEL_TWO_MASK);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      level_one_reg <= `LEVEL_RESET;
      level_two_reg <= `LEVEL_RESET;
    end else begin
      level_one_reg <= next_level_one;
      level_two_reg <= next_level_two;
    end
  end

  // Abort and external fields are held but feed no source.
  assign level_one = level_one_t'(level_one_reg);
  assign level_two = level_two_t'(level_two_reg);

  // Bit i of the vector pairs with clear bit i+8. An event in the cycle of
  // its clear wins, so no edge is lost. Enables play no part here.
  always_comb begin
    next_pending = (pending & ~clear_bits) | source_event;
    // Bits 22 and 19 (abort and external, clear bits 30 and 27) have no source and stay zero.
    next_pending = next_pending & ~`UNUSED_SRC_MASK;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pending <= `PEND_RESET;
    end else begin
      pending <= next_pending;
    end
  end

  // A source with no level field here passes its pending state through;
  // its level lives in another word.
  always_comb begin
    level_request = pending;
    level_request[`IDX_TIMER_A]     = pending[`IDX_TIMER_A] &
      (level_one.timer_a_priority != 3'h0);
    level_request[`IDX_TIMER_B]     = pending[`IDX_TIMER_B] &
      (level_one.timer_b_priority != 3'h0);
    level_request[`IDX_IRQ1_EDGE]   = pending[`IDX_IRQ1_EDGE] &
      (level_one.bus_irq1_edge_priority != 3'h0);
    level_request[`IDX_WRITE_POST]  = pending[`IDX_WRITE_POST] &
      (level_one.posted_write_error_priority != 3'h0);
    level_request[`IDX_SYSTEM_FAIL] = pending[`IDX_SYSTEM_FAIL] &
      (level_one.system_fail_priority != 3'h0);
    level_request[`IDX_POWER_FAIL]  = pending[`IDX_POWER_FAIL] &
      (level_one.power_fail_priority != 3'h0);
    level_request[`IDX_DMA]         = pending[`IDX_DMA] &
      (level_two.dma_priority != 3'h0);
    level_request[`IDX_INTR_ACK]    = pending[`IDX_INTR_ACK] &
      (level_two.intr_ack_priority != 3'h0);
    level_request[`IDX_MAILBOX2]    = pending[`IDX_MAILBOX2] &
      (level_two.mailbox_signal2_priority != 3'h0);
    level_request[`IDX_MAILBOX3]    = pending[`IDX_MAILBOX3] &
      (level_two.mailbox_signal3_priority != 3'h0);
  end

  // Read data is loaded in the setup cycle so it stands from a flop
  // through the access phase. The clear word reads as zero.
  always_comb begin
    next_prdata = prdata;
    if (psel && !penable && !pwrite) begin
      if (hit_one) begin
        next_prdata = level_one_reg;
      end else if (hit_two) begin
        next_prdata = level_two_reg;
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

endmodule // local_irq_clear_and_level_map

/* bench/irq_map_sva.sv */
// Checker for the clear and level map, on top-level ports only.
// Assumes the block header is on the include path; bound below.
`timescale 1ns/100ps
`include "irq_clear_level_cfg.svh"
module irq_map_sva
  import irq_clear_level_pkg::*;
(
  input wire logic        clock,         // Clock.
  input wire logic        reset,         // Reset.
  input wire logic        psel,          // Select.
  input wire logic        penable,       // Access.
  input wire logic        pwrite,        // Write.
  input wire logic [31:0] paddr,         // Address.
  input wire logic [31:0] pwdata,        // Data.
  input wire logic [3:0]  pstrb,         // Strobes.
  input wire logic        pslverr,       // Error.
  input wire logic [23:0] source_event,  // Events.
  input wire logic [23:0] pending,       // Pending.
  input wire logic [23:0] level_request, // Requests.
  input wire level_one_t  level_one      // Levels.
);
  logic [23:0] wipe;
  logic        hit;
  logic        ok;
  always_comb begin
    ok   = paddr inside {`EDGE_CLEAR_OFS, `LEVEL_ONE_OFS, `LEVEL_TWO_OFS};
    hit  = psel && penable && pwrite && paddr == `EDGE_CLEAR_OFS;
    wipe = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}} & pwdata[31:8];
    if (!hit)
      wipe = 24'h00_0000;
  end
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  a_event_sets: assert property (
    1 |=> (~pending & $past(source_event) & ~`UNUSED_SRC_MASK) == 24'h0)
    else $error("event did not set pending");
  a_clear_drops: assert property (
    hit && source_event == 24'h0 |=> (pending & $past(wipe)) == 24'h0)
    else $error("clear left pending set");
  a_zero_keeps: assert property (
    1 |=> (~pending & $past(pending) & ~$past(wipe)) == 24'h0)
    else $error("pending fell without clear");
  a_no_spurious: assert property (
    (pending & ~$past(pending) & ~$past(source_event)) == 24'h0)
    else $error("pending rose without event");
  a_unused_zero: assert property (
    (pending & `UNUSED_SRC_MASK) == 24'h0)
    else $error("unused source pending");
  a_unmapped_err: assert property (
    psel && penable |-> pslverr == !ok)
    else $error("pslverr wrong");
  a_lreq_pass: assert property (
    level_request[11:0] == pending[11:0])
    else $error("request not passed");
  a_lreq_gate: assert property (
    level_request[16] == (pending[16] && level_one.timer_a_priority != 3'h0)
    && level_request[23] ==
    (pending[23] && level_one.power_fail_priority != 3'h0))
    else $error("request gate wrong");
endmodule // irq_map_sva
bind local_irq_clear_and_level_map irq_map_sva i_sva (.*);

/* bench/local_irq_clear_and_level_map_tb_top.sv */
// Testbench for the clear and level map: APB traffic and event pulses.
// Assumes design, package and header are compiled before it.
`timescale 1ns/100ps
`include "irq_clear_level_cfg.svh"
module local_irq_clear_and_level_map_tb_top
  import irq_clear_level_pkg::*;
;
  logic        clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr;
  logic [31:0] paddr = '0, pwdata = '0, prdata, l1 = '0, l2 = '0, r;
  logic [3:0]  pstrb = '0, s;
  logic [23:0] source_event = '0, pending, level_request, pexp = '0;
  level_one_t  level_one;
  level_two_t  level_two;
  logic [31:0] exp_q[$];
  int          err_total = 0, compares = 0;
  always #10 clock = ~clock;
  local_irq_clear_and_level_map i_dut (.*);
  task automatic compare(string what, logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic apb(logic w, logic [31:0] a, d, logic [3:0] st);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
  endtask
  task automatic rd(logic [31:0] a, e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask
  function automatic logic [31:0] merge(logic [31:0] o, d, logic [3:0] st,
                                        logic [31:0] m);
    logic [31:0] b;
    b = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}} & m;
    return (o & ~b) | (d & b);
  endfunction
  function automatic logic [23:0] lreq();
    int          ix[10] = '{16, 17, 18, 20, 21, 23, 14, 15, 12, 13};
    int          lo[10] = '{0, 3, 8, 16, 19, 27, 56, 59, 48, 51};
    logic [63:0] lv;
    lv = {l2, l1};
    lreq = pexp;
    for (int k = 0; k < 10; k++)
      lreq[ix[k]] &= (lv[lo[k] +: 3] != 3'h0);
  endfunction
  task automatic chk();
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clock);
    compare("pending", {8'h0, pexp}, {8'h0, pending});
    compare("request", {8'h0, lreq()}, {8'h0, level_request});
    compare("level_one", l1, level_one);
    compare("level_two", l2, level_two);
    @(posedge clock);
  endtask
  task automatic give_verdict();
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Reads are judged where the bus completes them, in issue order.
  // Only the three mapped words answer without an error.
  always @(posedge clock)
    if (psel && penable && pready) begin
      compare("pslverr", {31'h0, !(paddr inside {`EDGE_CLEAR_OFS,
              `LEVEL_ONE_OFS, `LEVEL_TWO_OFS})}, {31'h0, pslverr});
      if (!pwrite)
        compare("prdata", exp_q.pop_front(), prdata);
    end
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
  initial begin
    r = $urandom(10);
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd(`LEVEL_ONE_OFS, `LEVEL_RESET);
    rd(`LEVEL_TWO_OFS, `LEVEL_RESET);
    rd(32'hFFF4_0080, 32'h0);
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      s = (i < 3) ? 4'hF : 4'($urandom);
      apb(1'b1, `LEVEL_ONE_OFS, r, s);
      l1 = merge(l1, r, s, `LEVEL_ONE_MASK);
      apb(1'b1, `LEVEL_TWO_OFS, ~r, s);
      l2 = merge(l2, ~r, s, `LEVEL_TWO_MASK);
      rd(`LEVEL_ONE_OFS, l1);
      rd(`LEVEL_TWO_OFS, l2);
      rd(`EDGE_CLEAR_OFS, 32'h0);
      chk();
      r = $urandom;
      source_event <= r[23:0];
      @(posedge clock);
      source_event <= 24'h00_0000;
      pexp = pexp | (r[23:0] & ~`UNUSED_SRC_MASK);
      chk();
      r = $urandom;
      apb(1'b1, `EDGE_CLEAR_OFS, r, s);
      pexp = pexp & ~(r[31:8] & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}});
      chk();
    end
    apb(1'b1, 32'hFFF4_0080, 32'hFFFF_FFFF, 4'hF);
    chk();
    // A second reset in mid-run must bring every level back to zero.
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    {l1, l2, pexp} = '0;
    rd(`LEVEL_ONE_OFS, `LEVEL_RESET);
    chk();
    // Events held through a full clear: the set must win.
    source_event <= 24'h80_4001;
    apb(1'b1, `EDGE_CLEAR_OFS, 32'hFFFF_FF00, 4'hF);
    source_event <= 24'h00_0000;
    pexp = 24'h80_4001;
    chk();
    source_event <= 24'hFF_FFFF;
    @(posedge clock);
    source_event <= 24'h00_0000;
    pexp = ~`UNUSED_SRC_MASK;
    for (int i = 0; i < 24; i++) begin
      apb(1'b1, `EDGE_CLEAR_OFS, 32'h100 << i, 4'hF);
      pexp[i] = 1'b0;
      chk();
    end
    give_verdict();
  end
endmodule // local_irq_clear_and_level_map_tb_top
